/* File: lcs_deglitch.sv */
// Persistence filter that takes a new input level after a fixed run of millisecond ticks.

`timescale 1ns/10ps
`default_nettype none

module lcs_deglitch #(
  parameter logic [lcs_pkg::DGL_W-1:0] DGL_MS = lcs_pkg::PIN_DGL_MS
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Millisecond tick and filtered raw level.
  input wire logic i_ms_tick,
  input wire logic i_raw,
  // Accepted level.
  output logic o_level
);
  lcs_pkg::lcs_dgl_type r, n;

  // A new level is taken only after it has differed from the held one for DGL_MS ticks.
  always_comb begin
    n = r;
    if (i_raw == r.level) begin
      n.cnt = '0;
    end else if (i_ms_tick) begin
      if (r.cnt == DGL_MS - 9'h001) begin
        n.cnt = '0;
        n.level = i_raw;
      end else begin
        n.cnt = r.cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_level = r.level;

  a_level_after_count: assert property (@(posedge i_core_clk) disable iff (i_rst)
      $changed(r.level) |-> $past(r.cnt) == DGL_MS - 9'h001 && $past(i_ms_tick)) // R2 R3 R4
    else $error("deglitch level changed before its interval ran out");
endmodule

`default_nettype wire

/* File: lcs_charge_seq.sv */
// Charge sequencer package and top: supply choice, charge phases, safety timers, status pins.
// What this block does
// [R1] Abort fast plus constant-voltage charge after 300 minutes, 600 with long timer.
// [R2] Accept end-of-charge and top-off current only after 300 ms persistence.
// [R3] Act on battery temperature fault only after 40 ms persistence.
// [R4] Inhibit and current-select levels are taken after 40 ms stable.
// [R5] Power down when both supplies drop below battery plus headroom.
// [R6] Power-down turns charge off and releases both status outputs.
// [R7] Wake when either supply rises above battery plus headroom.
// [R8] No charge phase starts until the selected supply passes the wake threshold.
// [R9] With both supplies valid the adapter is the charge source.
// [R10] The bus supply is used only when the adapter is absent or too low.
// [R11] Precharge drives output A, releases B, charges at 50 mA.
// [R12] Precharge moves to fast charge at the fast-charge threshold.
// [R13] Precharge timeout stops charge, drives both outputs, latches bad battery.
// [R14] Fast charge starts the charge timer, drives A, releases B.
// [R15] On bus supply, current select low gives 100 mA, high 500 mA.
// [R16] At 4.2 V go constant voltage; timer and outputs unchanged.
// [R17] End of charge is current down to 10 percent of full rate.
// [R18] Charge timeout before end of charge latches bad battery, both outputs on.
// [R19] Top-off ends at 2.5 percent current or 30/60 minute timer.
// [R20] Top-off done releases A, drives B, enters maintenance.
// [R21] Maintenance restarts fast charge when battery falls 200 mV below termination.
// [R22] A maintenance restart resets timers, drives A and releases B.
// [R23] Precharge timer starts on precharge entry and allows 30 minutes.
// [R24] Bad battery clears only by removal of the input supply.
// [R25] Temperature fault suspends charge, releases outputs, holds the timer.
// [R26] Inhibit high interrupts charge, low resumes; timers hold, outputs released.
// [R27] All timers and deglitch intervals come from one shared prescaler.

`timescale 1ns/10ps
`default_nettype none

package lcs_pkg;
  // Core clock and the millisecond prescale derived from it.
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned MS_PER_MIN = 60_000;
  localparam int unsigned CYC_W = 18;
  localparam int unsigned MSC_W = 16;
  localparam int unsigned MIN_W = 10;
  localparam int unsigned DGL_W = 9;
  // Safety timer limits in minutes.
  localparam logic [MIN_W-1:0] PRECHARGE_TIMER_MIN = 10'h01e;
  localparam logic [MIN_W-1:0] CHARGE_TIMER_MIN = 10'h12c;
  localparam logic [MIN_W-1:0] CHARGE_TIMER_LONG_MIN = 10'h258;
  localparam logic [MIN_W-1:0] TOPOFF_TIMER_MIN = 10'h01e;
  localparam logic [MIN_W-1:0] TOPOFF_TIMER_LONG_MIN = 10'h03c;
  // Deglitch intervals in milliseconds.
  localparam logic [DGL_W-1:0] EOC_DGL_MS = 9'h12c;
  localparam logic [DGL_W-1:0] TOPOFF_DGL_MS = 9'h12c;
  localparam logic [DGL_W-1:0] TEMP_DGL_MS = 9'h028;
  localparam logic [DGL_W-1:0] PIN_DGL_MS = 9'h028;
  // Positions of the comparator and pin inputs in the input vector.
  localparam int unsigned IN_ADP_OK = 0;
  localparam int unsigned IN_BUS_OK = 1;
  localparam int unsigned IN_ADP_ABOVE = 2;
  localparam int unsigned IN_ADP_POR = 3;
  localparam int unsigned IN_BUS_POR = 4;
  localparam int unsigned IN_FAST = 5;
  localparam int unsigned IN_TERM = 6;
  localparam int unsigned IN_RESTART = 7;
  localparam int unsigned IN_EOC = 8;
  localparam int unsigned IN_TOPOFF = 9;
  localparam int unsigned IN_TEMP = 10;
  localparam int unsigned IN_INHIBIT = 11;
  localparam int unsigned IN_SEL = 12;
  localparam int unsigned NUM_IN = 13;
  // Deglitched channels: index, source input and interval.
  localparam int unsigned DG_EOC = 0;
  localparam int unsigned DG_TOPOFF = 1;
  localparam int unsigned DG_TEMP = 2;
  localparam int unsigned DG_INHIBIT = 3;
  localparam int unsigned DG_SEL = 4;
  localparam int unsigned NUM_DG = 5;
  localparam int unsigned DG_SRC [NUM_DG] = '{IN_EOC, IN_TOPOFF, IN_TEMP, IN_INHIBIT, IN_SEL};
  localparam logic [DGL_W-1:0] DG_MS [NUM_DG] =
      '{EOC_DGL_MS, TOPOFF_DGL_MS, TEMP_DGL_MS, PIN_DGL_MS, PIN_DGL_MS};

  typedef enum logic [2:0] {
    ST_PWRDN, ST_WAIT_POR, ST_PRECHARGE, ST_FAST, ST_CV, ST_TOPOFF, ST_MAINT, ST_BAD
  } lcs_state_type;

  typedef struct packed {
    logic [DGL_W-1:0] cnt;
    logic level;
  } lcs_dgl_type;

  typedef struct packed {
    logic [NUM_IN-1:0] s1;
    logic [NUM_IN-1:0] s2;
    logic [NUM_IN-1:0] s3;
    logic [NUM_IN-1:0] filt;
    logic [CYC_W-1:0] cyc;
    logic ms_tick;
    logic [MSC_W-1:0] ms_in_min;
    logic [MIN_W-1:0] minutes;
    lcs_state_type st;
    logic chg_en;
    logic precharge;
    logic cv;
    logic sel_adp;
    logic sel_bus;
    logic bus_hi;
    logic bad;
    logic stat_a;
    logic stat_b;
    logic od_low;
  } lcs_core_type;
endpackage

module lcs_charge_seq #(
  parameter int unsigned MS_CYCLES = lcs_pkg::CYC_PER_MS,
  parameter int unsigned MS_PER_MIN = lcs_pkg::MS_PER_MIN,
  parameter logic LONG_TIMER_VARIANT = 1'b1
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Supply comparators.
  input wire logic i_adapter_supply_in_ok,
  input wire logic i_bus_supply_in_ok,
  input wire logic i_adapter_supply_in_above_batt,
  input wire logic i_adapter_supply_in_wake,
  input wire logic i_bus_supply_in_wake,
  // Battery voltage and current comparators.
  input wire logic i_batt_fast_ok,
  input wire logic i_batt_term_reached,
  input wire logic i_batt_restart_low,
  input wire logic i_chg_cur_eoc,
  input wire logic i_chg_cur_topoff,
  input wire logic i_thermistor_input_fault,
  // Host control pins.
  input wire logic i_chg_inhibit,
  input wire logic i_cur_sel,
  // Charge path control.
  output logic o_charge_en,
  output logic o_precharge_50ma,
  output logic o_cv_mode,
  output logic o_sel_adapter,
  output logic o_sel_bus,
  output logic o_bus_500ma,
  output logic o_bad_battery,
  // Open-drain status outputs.
  output logic o_status_out_a_o,
  output logic o_status_out_a_oe,
  output logic o_status_out_b_o,
  output logic o_status_out_b_oe
);
  lcs_pkg::lcs_core_type r, n;
  logic [lcs_pkg::NUM_IN-1:0] pins;
  logic [lcs_pkg::NUM_IN-1:0] agree;
  logic [lcs_pkg::NUM_DG-1:0] dg;
  logic [lcs_pkg::NUM_DG-1:0] dg_clr;
  logic powered;
  logic use_adp;
  logic wake_ok;
  logic suspend;
  logic long_sel;
  logic timing;
  logic restart;
  logic [lcs_pkg::MIN_W-1:0] chg_lim;
  logic [lcs_pkg::MIN_W-1:0] top_lim;

  assign pins = {i_cur_sel, i_chg_inhibit, i_thermistor_input_fault, i_chg_cur_topoff,
                 i_chg_cur_eoc, i_batt_restart_low, i_batt_term_reached, i_batt_fast_ok,
                 i_bus_supply_in_wake, i_adapter_supply_in_wake,
                 i_adapter_supply_in_above_batt, i_bus_supply_in_ok, i_adapter_supply_in_ok};
  assign agree = ~(r.s2 ^ r.s3);
  // Current filters restart on entry to the phase that reads them, so no stale level ends it.
  assign dg_clr = {3'h0, r.st != lcs_pkg::ST_TOPOFF, r.st != lcs_pkg::ST_CV}; // R2 R19

  // One persistence filter per deglitched channel, all on the shared millisecond tick.
  for (genvar g = 0; g < lcs_pkg::NUM_DG; g++) begin : g_dgl
    lcs_deglitch #(
      .DGL_MS(lcs_pkg::DG_MS[g])
    ) u_dgl (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst || dg_clr[g]),
      .i_ms_tick(r.ms_tick), // R27
      .i_raw(r.filt[lcs_pkg::DG_SRC[g]]), // R2 R3 R4
      .o_level(dg[g])
    );
  end

  always_comb begin
    n = r;
    restart = 1'b0;
    // Three-stage synchroniser; a change counts once stages two and three agree.
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.filt = (r.filt & ~agree) | (r.s3 & agree);
    // Shared millisecond prescaler, free running.
    if (r.cyc == lcs_pkg::CYC_W'(MS_CYCLES - 1)) begin
      n.cyc = '0;
      n.ms_tick = 1'b1; // R27
    end else begin
      n.cyc = r.cyc + 18'h0_0001;
      n.ms_tick = 1'b0;
    end
    // Supply state.
    powered = r.filt[lcs_pkg::IN_ADP_OK] | r.filt[lcs_pkg::IN_BUS_OK]; // R5 R7
    use_adp = r.filt[lcs_pkg::IN_ADP_OK] & r.filt[lcs_pkg::IN_ADP_ABOVE]; // R9 R10
    wake_ok = use_adp ? r.filt[lcs_pkg::IN_ADP_POR] : r.filt[lcs_pkg::IN_BUS_POR]; // R8
    suspend = dg[lcs_pkg::DG_TEMP] | dg[lcs_pkg::DG_INHIBIT]; // R25 R26
    long_sel = LONG_TIMER_VARIANT & ~dg[lcs_pkg::DG_SEL];
    chg_lim = long_sel ? lcs_pkg::CHARGE_TIMER_LONG_MIN : lcs_pkg::CHARGE_TIMER_MIN; // R1
    top_lim = long_sel ? lcs_pkg::TOPOFF_TIMER_LONG_MIN : lcs_pkg::TOPOFF_TIMER_MIN; // R19
    timing = (r.st inside {lcs_pkg::ST_PRECHARGE, lcs_pkg::ST_FAST, lcs_pkg::ST_CV,
                           lcs_pkg::ST_TOPOFF}) && !suspend; // R25 R26
    // Phase sequencing.
    if (!powered) begin
      n.st = lcs_pkg::ST_PWRDN; // R5 R24
    end else begin
      unique case (r.st)
        lcs_pkg::ST_PWRDN: begin
          n.st = lcs_pkg::ST_WAIT_POR; // R7
        end
        lcs_pkg::ST_WAIT_POR: begin
          if (wake_ok) begin
            n.st = lcs_pkg::ST_PRECHARGE; // R8
            restart = 1'b1; // R23
          end
        end
        lcs_pkg::ST_PRECHARGE: begin
          if (!suspend) begin
            if (r.filt[lcs_pkg::IN_FAST]) begin
              n.st = lcs_pkg::ST_FAST; // R12
              restart = 1'b1; // R14
            end else if (r.minutes >= lcs_pkg::PRECHARGE_TIMER_MIN) begin
              n.st = lcs_pkg::ST_BAD; // R13 R23
            end
          end
        end
        lcs_pkg::ST_FAST: begin
          if (!suspend) begin
            if (r.minutes >= chg_lim) begin
              n.st = lcs_pkg::ST_BAD; // R1 R18
            end else if (r.filt[lcs_pkg::IN_TERM]) begin
              n.st = lcs_pkg::ST_CV; // R16
            end
          end
        end
        lcs_pkg::ST_CV: begin
          if (!suspend) begin
            if (r.minutes >= chg_lim) begin
              n.st = lcs_pkg::ST_BAD; // R1 R18
            end else if (dg[lcs_pkg::DG_EOC]) begin
              n.st = lcs_pkg::ST_TOPOFF; // R17
              restart = 1'b1;
            end
          end
        end
        lcs_pkg::ST_TOPOFF: begin
          if (!suspend && (dg[lcs_pkg::DG_TOPOFF] || r.minutes >= top_lim)) begin
            n.st = lcs_pkg::ST_MAINT; // R19 R20
          end
        end
        lcs_pkg::ST_MAINT: begin
          if (r.filt[lcs_pkg::IN_RESTART]) begin
            n.st = lcs_pkg::ST_FAST; // R21
            restart = 1'b1; // R22
          end
        end
        lcs_pkg::ST_BAD: begin
          n.st = lcs_pkg::ST_BAD; // R24
        end
      endcase
    end
    // Phase timer: minutes from the shared tick, held while suspended.
    if (restart || !powered) begin
      n.ms_in_min = '0;
      n.minutes = '0;
    end else if (timing && r.ms_tick) begin
      if (r.ms_in_min == lcs_pkg::MSC_W'(MS_PER_MIN - 1)) begin
        n.ms_in_min = '0;
        n.minutes = r.minutes + 10'h001;
      end else begin
        n.ms_in_min = r.ms_in_min + 16'h0001;
      end
    end
    // Outputs follow the next phase.
    n.chg_en = (n.st inside {lcs_pkg::ST_PRECHARGE, lcs_pkg::ST_FAST, lcs_pkg::ST_CV,
                             lcs_pkg::ST_TOPOFF}) && !suspend; // R6 R25 R26
    n.precharge = n.chg_en && n.st == lcs_pkg::ST_PRECHARGE; // R11
    n.cv = n.chg_en && (n.st inside {lcs_pkg::ST_CV, lcs_pkg::ST_TOPOFF}); // R16
    n.sel_adp = powered && use_adp; // R9
    n.sel_bus = powered && !use_adp && r.filt[lcs_pkg::IN_BUS_OK]; // R10
    n.bus_hi = n.sel_bus && dg[lcs_pkg::DG_SEL]; // R15
    n.bad = n.st == lcs_pkg::ST_BAD; // R13 R18
    n.stat_a = n.chg_en || n.bad; // R11 R14 R22
    n.stat_b = n.bad || (n.st == lcs_pkg::ST_MAINT && !suspend); // R20
    n.od_low = 1'b0;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_charge_en = r.chg_en;
  assign o_precharge_50ma = r.precharge;
  assign o_cv_mode = r.cv;
  assign o_sel_adapter = r.sel_adp;
  assign o_sel_bus = r.sel_bus;
  assign o_bus_500ma = r.bus_hi;
  assign o_bad_battery = r.bad;
  assign o_status_out_a_o = r.od_low;
  assign o_status_out_a_oe = r.stat_a;
  assign o_status_out_b_o = r.od_low;
  assign o_status_out_b_oe = r.stat_b;

  a_supply_loss_down: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !powered |=> r.st == lcs_pkg::ST_PWRDN ##1 !r.stat_a && !r.stat_b) // R5
    else $error("supply loss did not power down");

  a_pwrdn_released: assert property (@(posedge i_core_clk) disable iff (i_rst)
      r.st == lcs_pkg::ST_PWRDN |-> !r.stat_a && !r.stat_b && !r.chg_en) // R6
    else $error("power-down left a status output or charge on");

  a_wake_either: assert property (@(posedge i_core_clk) disable iff (i_rst)
      r.st == lcs_pkg::ST_PWRDN && powered |=> r.st == lcs_pkg::ST_WAIT_POR) // R7
    else $error("no wake with a supply present");

  a_wake_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
      r.st == lcs_pkg::ST_WAIT_POR && !wake_ok |=> r.st != lcs_pkg::ST_PRECHARGE) // R8
    else $error("charge started below wake threshold");

  a_adapter_first: assert property (@(posedge i_core_clk) disable iff (i_rst)
      use_adp |=> r.sel_adp && !r.sel_bus) // R9
    else $error("adapter not chosen first");

  a_bad_pattern: assert property (@(posedge i_core_clk) disable iff (i_rst)
      r.st == lcs_pkg::ST_BAD |-> r.stat_a && r.stat_b && !r.chg_en && r.bad) // R13
    else $error("bad battery pattern wrong");

  a_bad_sticky: assert property (@(posedge i_core_clk) disable iff (i_rst)
      r.st == lcs_pkg::ST_BAD && powered |=> r.st == lcs_pkg::ST_BAD) // R24
    else $error("bad battery cleared without supply removal");

  a_fast_entry: assert property (@(posedge i_core_clk) disable iff (i_rst)
      r.st == lcs_pkg::ST_PRECHARGE && powered && !suspend && r.filt[lcs_pkg::IN_FAST]
      |=> r.st == lcs_pkg::ST_FAST && r.minutes == '0 && r.stat_a && !r.stat_b) // R14
    else $error("fast charge entry wrong");

  a_charge_timeout: assert property (@(posedge i_core_clk) disable iff (i_rst)
      r.st inside {lcs_pkg::ST_FAST, lcs_pkg::ST_CV} && powered && !suspend && r.minutes >= chg_lim
      |=> r.st == lcs_pkg::ST_BAD) // R18
    else $error("charge timer expiry ignored");

  a_restart_reset: assert property (@(posedge i_core_clk) disable iff (i_rst)
      r.st == lcs_pkg::ST_MAINT && powered && r.filt[lcs_pkg::IN_RESTART]
      |=> r.st == lcs_pkg::ST_FAST && r.minutes == '0 && r.ms_in_min == '0) // R22
    else $error("maintenance restart did not reset timers");

  a_suspend_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
      suspend && powered && r.st == lcs_pkg::ST_FAST
      |=> $stable(r.minutes) && !r.stat_a && !r.chg_en) // R25
    else $error("suspend did not hold timer or release outputs");
endmodule

`default_nettype wire

/* File: lcs_batt_model.sv */
// Model of the battery, the two supplies and the status pin pull-ups.
`timescale 1ns/10ps
`default_nettype none
module lcs_batt_model #(
  parameter int HEADROOM_MV = 100,
  parameter int WAKE_MV = 4300,
  parameter int FAST_MV = 3000,
  parameter int TERM_MV = 4200,
  parameter int RESTART_DROP_MV = 200,
  parameter int EOC_PM = 100,
  parameter int TOPOFF_PM = 25
) (
  // Supply and battery voltages in mV, charge current in per mille of full rate.
  input wire logic [15:0] i_adp_mv,
  input wire logic [15:0] i_bus_mv,
  input wire logic [15:0] i_batt_mv,
  input wire logic [9:0] i_cur_pm,
  // Open-drain status pins as driven by the sequencer.
  input wire logic i_a_o,
  input wire logic i_a_oe,
  input wire logic i_b_o,
  input wire logic i_b_oe,
  // Comparator levels.
  output logic o_adp_ok,
  output logic o_bus_ok,
  output logic o_adp_above,
  output logic o_adp_wake,
  output logic o_bus_wake,
  output logic o_fast_ok,
  output logic o_term,
  output logic o_restart_low,
  output logic o_eoc,
  output logic o_topoff,
  // Pin levels seen through the pull-ups.
  output logic o_a_line,
  output logic o_b_line
);
  int adp;
  int bus;
  int batt;
  int cur;
  assign adp = int'(i_adp_mv);
  assign bus = int'(i_bus_mv);
  assign batt = int'(i_batt_mv);
  assign cur = int'(i_cur_pm);
  assign o_adp_ok = adp >= batt + HEADROOM_MV;
  assign o_bus_ok = bus >= batt + HEADROOM_MV;
  assign o_adp_above = adp > batt;
  assign o_adp_wake = adp >= WAKE_MV;
  assign o_bus_wake = bus >= WAKE_MV;
  assign o_fast_ok = batt >= FAST_MV;
  assign o_term = batt >= TERM_MV;
  assign o_restart_low = batt <= TERM_MV - RESTART_DROP_MV;
  assign o_eoc = cur <= EOC_PM;
  assign o_topoff = cur <= TOPOFF_PM;
  // A released pin is pulled high; a driven pin shows the driven data.
  assign o_a_line = i_a_oe ? i_a_o : 1'h1;
  assign o_b_line = i_b_oe ? i_b_o : 1'h1;
endmodule
`default_nettype wire

/* File: test_li_ion_charge_sequencer.sv */
// Self-checking testbench of the charge sequencer with a battery model.
`timescale 1ns/10ps
`default_nettype none
module test_li_ion_charge_sequencer;
  localparam int MS = 4;
  localparam int MIN = MS * 10;
  localparam int DG_LONG = 300 * MS;
  localparam int DG_SHORT = 40 * MS;
  localparam logic [15:0] V0 = 16'h0000;
  localparam logic [15:0] V25 = 16'h09c4;
  localparam logic [15:0] V30 = 16'h0bb8;
  localparam logic [15:0] V35 = 16'h0dac;
  localparam logic [15:0] V39 = 16'h0f3c;
  localparam logic [15:0] V40 = 16'h0fa0;
  localparam logic [15:0] V42 = 16'h1068;
  localparam logic [15:0] V50 = 16'h1388;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [15:0] adp_mv = V0;
  logic [15:0] bus_mv = V0;
  logic [15:0] batt_mv = V25;
  logic [9:0] cur_pm = 10'h3e8;
  logic temp_fault = 1'h0;
  logic inhibit = 1'h0;
  logic cur_sel = 1'h0;
  logic adp_ok, bus_ok, adp_above, adp_wake, bus_wake, fast_ok, term, restart_low;
  logic eoc, topoff, a_line, b_line;
  logic charge_en, pre50, cv, sel_adp, sel_bus, bus500, bad;
  logic a_o, a_oe, b_o, b_oe;
  int errors = 0;
  int n_checks = 0;

  lcs_batt_model lcs_batt_model_inst (.i_adp_mv(adp_mv), .i_bus_mv(bus_mv),
    .i_batt_mv(batt_mv), .i_cur_pm(cur_pm), .i_a_o(a_o), .i_a_oe(a_oe), .i_b_o(b_o),
    .i_b_oe(b_oe), .o_adp_ok(adp_ok), .o_bus_ok(bus_ok), .o_adp_above(adp_above),
    .o_adp_wake(adp_wake), .o_bus_wake(bus_wake), .o_fast_ok(fast_ok), .o_term(term),
    .o_restart_low(restart_low), .o_eoc(eoc), .o_topoff(topoff), .o_a_line(a_line),
    .o_b_line(b_line));

  lcs_charge_seq #(.MS_CYCLES(MS), .MS_PER_MIN(10)) lcs_charge_seq_inst (
    .i_core_clk(clk), .i_rst(rst), .i_adapter_supply_in_ok(adp_ok),
    .i_bus_supply_in_ok(bus_ok), .i_adapter_supply_in_above_batt(adp_above),
    .i_adapter_supply_in_wake(adp_wake), .i_bus_supply_in_wake(bus_wake),
    .i_batt_fast_ok(fast_ok), .i_batt_term_reached(term), .i_batt_restart_low(restart_low),
    .i_chg_cur_eoc(eoc), .i_chg_cur_topoff(topoff), .i_thermistor_input_fault(temp_fault),
    .i_chg_inhibit(inhibit), .i_cur_sel(cur_sel), .o_charge_en(charge_en),
    .o_precharge_50ma(pre50), .o_cv_mode(cv), .o_sel_adapter(sel_adp), .o_sel_bus(sel_bus),
    .o_bus_500ma(bus500), .o_bad_battery(bad), .o_status_out_a_o(a_o),
    .o_status_out_a_oe(a_oe), .o_status_out_b_o(b_o), .o_status_out_b_oe(b_oe));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // Status pins: pulled low (ON) is a driven enable and a low line.
  task automatic pins(input logic a, input logic b, input string msg);
    chk(a_oe, a, msg);
    chk(a_line, ~a, msg);
    chk(b_oe, b, msg);
    chk(b_line, ~b, msg);
  endtask

  task automatic end_sim();
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic t_wake();
    adp_mv = V40;
    wt(12);
    chk(charge_en, 1'h0, "charge before wake threshold");
    pins(1'h0, 1'h0, "pins before wake threshold");
    adp_mv = V50;
    wt(10);
    chk(charge_en, 1'h1, "no precharge");
    chk(pre50, 1'h1, "no 50 mA mode");
    pins(1'h1, 1'h0, "precharge pins");
    bus_mv = V50;
    wt(10);
    chk(sel_adp, 1'h1, "adapter not chosen");
    chk(sel_bus, 1'h0, "bus chosen with adapter valid");
  endtask

  task automatic t_cycle();
    batt_mv = V35;
    wt(10);
    chk(pre50, 1'h0, "still precharge");
    pins(1'h1, 1'h0, "fast charge pins");
    batt_mv = V42;
    wt(10);
    chk(cv, 1'h1, "no constant voltage");
    pins(1'h1, 1'h0, "constant voltage pins");
    cur_pm = 10'h014;
    wt(DG_LONG - 20);
    pins(1'h1, 1'h0, "current accepted early");
    wt(DG_LONG + 60);
    pins(1'h0, 1'h1, "no charge complete");
    cur_pm = 10'h3e8;
    batt_mv = V39;
    wt(10);
    chk(cv, 1'h0, "restart not in fast charge");
    pins(1'h1, 1'h0, "restart pins");
    batt_mv = V42;
    cur_pm = 10'h05a;
    wt(DG_LONG + 58 * MIN);
    pins(1'h1, 1'h0, "top-off ended early");
    wt(4 * MIN + 40);
    pins(1'h0, 1'h1, "top-off timer did not end");
    batt_mv = V39;
    wt(10);
  endtask

  task automatic set_susp(input int ch, input logic v);
    if (ch == 0) begin
      temp_fault = v;
    end else begin
      inhibit = v;
    end
  endtask

  task automatic t_suspend();
    for (int ch = 0; ch < 2; ch++) begin
      set_susp(ch, 1'h1);
      wt(100);
      set_susp(ch, 1'h0);
      wt(DG_SHORT);
      chk(charge_en, 1'h1, "short pulse suspended charge");
      set_susp(ch, 1'h1);
      wt(DG_SHORT - 20);
      chk(charge_en, 1'h1, "suspended before deglitch");
      wt(40);
      chk(charge_en, 1'h0, "charge not suspended");
      pins(1'h0, 1'h0, "pins not released");
      set_susp(ch, 1'h0);
      wt(DG_SHORT + 20);
      chk(charge_en, 1'h1, "charge not resumed");
      pins(1'h1, 1'h0, "pins after resume");
    end
  endtask

  task automatic t_bus();
    adp_mv = V30;
    wt(10);
    chk(sel_bus, 1'h1, "bus not chosen");
    chk(sel_adp, 1'h0, "adapter below battery chosen");
    chk(bus500, 1'h0, "not 100 mA with select low");
    cur_sel = 1'h1;
    wt(DG_SHORT - 20);
    chk(bus500, 1'h0, "select taken before deglitch");
    wt(40);
    chk(bus500, 1'h1, "not 500 mA with select high");
  endtask

  task automatic t_timeout();
    adp_mv = V0;
    bus_mv = V0;
    wt(10);
    chk(charge_en, 1'h0, "charge on in power-down");
    pins(1'h0, 1'h0, "pins in power-down");
    bus_mv = V50;
    batt_mv = V35;
    wt(12);
    chk(charge_en, 1'h1, "no fast charge");
    wt(298 * MIN);
    chk(bad, 1'h0, "charge timer early");
    wt(4 * MIN);
    chk(bad, 1'h1, "charge timer did not expire");
    chk(charge_en, 1'h0, "charging after timeout");
    pins(1'h1, 1'h1, "bad battery pins");
    inhibit = 1'h1;
    wt(DG_SHORT + 20);
    inhibit = 1'h0;
    wt(DG_SHORT + 20);
    chk(bad, 1'h1, "bad battery cleared by inhibit");
    bus_mv = V0;
    wt(10);
    chk(bad, 1'h0, "bad battery kept after supply loss");
    pins(1'h0, 1'h0, "pins after supply loss");
  endtask

  task automatic precharge_timer();
    bus_mv = V50;
    batt_mv = V25;
    wt(12);
    chk(pre50, 1'h1, "no precharge");
    wt(28 * MIN);
    chk(bad, 1'h0, "precharge timer early");
    wt(4 * MIN);
    chk(bad, 1'h1, "precharge timer did not expire");
    chk(charge_en, 1'h0, "charging after timeout");
    pins(1'h1, 1'h1, "bad battery pins");
  endtask

  initial begin
    wt(4);
    chk(charge_en, 1'h0, "charge on in reset");
    pins(1'h0, 1'h0, "pins in reset");
    rst = 1'h0;
    wt(2);
    t_wake();
    t_cycle();
    t_suspend();
    t_bus();
    t_timeout();
    precharge_timer();
    end_sim();
  end

  initial begin
    #(4 * 80000);
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
